// ---- siu_pkg.sv ----
// Package of the status and interrupt unit: register map, field
// positions, reset values and lock codes.
// Assumes a serial front end that decodes page, address and data words.
package siu_pkg;
  localparam int unsigned DW = 24;

  // Pages and addresses
  localparam logic [7:0] PAGE_CTRL     = 8'h00;
  localparam logic [7:0] PAGE_CAL      = 8'h10;
  localparam logic [5:0] ADDR_ENABLE   = 6'h03;
  localparam logic [5:0] ADDR_STATUS   = 6'h17;
  localparam logic [5:0] ADDR_COND     = 6'h18;
  localparam logic [5:0] ADDR_SIGN     = 6'h19;
  localparam logic [5:0] ADDR_LOCK     = 6'h22;
  localparam logic [5:0] ADDR_CHECKSUM = 6'h01;
  localparam logic [5:0] ADDR_RATIO    = 6'h31;

  // Reset values
  localparam logic [DW-1:0] RST_ZERO  = 24'h00_0000;
  localparam logic [DW-1:0] RST_RATIO = 24'h01_999a;

  // Event status bit positions
  localparam int unsigned B_LOW_RATE   = 23;
  localparam int unsigned B_SAMPLE     = 22;
  localparam int unsigned B_WATCHDOG   = 21;
  localparam int unsigned B_OVERRUN    = 18;
  localparam int unsigned B_SWELL      = 16;
  localparam int unsigned B_POWER_RNG  = 14;
  localparam int unsigned B_CURR_RNG   = 12;
  localparam int unsigned B_VOLT_RNG   = 10;
  localparam int unsigned B_OVERCURR   = 8;
  localparam int unsigned B_SAG        = 6;
  localparam int unsigned B_TEMP_UPD   = 5;
  localparam int unsigned B_FREQ_UPD   = 4;
  localparam int unsigned B_BAD_CMD    = 3;
  localparam int unsigned B_RX_CSUM    = 2;
  localparam int unsigned B_RX_TIMEOUT = 0;
  // Bits that exist; the rest are reserved and read zero
  localparam logic [DW-1:0] STATUS_IMPL = 24'he5_557d;

  // Chip condition fields
  localparam int unsigned C_CMD_LO   = 8;
  localparam int unsigned C_TEMP_OSC = 3;
  localparam int unsigned C_VOLT_OSC = 2;
  localparam int unsigned C_CURR_OSC = 0;

  // Power sign fields
  localparam int unsigned S_REACT_TOT = 5;
  localparam int unsigned S_REACT_AVG = 3;
  localparam int unsigned S_ACT_TOT   = 2;
  localparam int unsigned S_ACT_AVG   = 0;

  // Host write lock field and codes
  localparam int unsigned LOCK_W      = 5;
  localparam logic [4:0]  LOCK_CODE   = 5'h16;
  localparam logic [4:0]  UNLOCK_CODE = 5'h09;
endpackage : siu_pkg

// ---- siu_flag_bank.sv ----
// Sticky event flag bank with write-one-to-clear.
// Assumes set and clear strobes are synchronous one-cycle pulses.
`timescale 1ns/100ps
module siu_flag_bank #(
  parameter int unsigned W = 24
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] set_evt,
  input  wire logic [W-1:0] clr_mask,
  output logic      [W-1:0] flags
);
  typedef struct packed {
    logic [W-1:0] flag;
  } siu_bank_s;

  siu_bank_s st_r;
  siu_bank_s st_nxt;

  initial begin
    if (W < 1) $error("siu_flag_bank: W must be at least one");
  end

  // Per bit: a set arriving with its clear wins, so no event is lost
  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < W; i++) begin
      if (set_evt[i])
        st_nxt.flag[i] = 1'b1;
      else if (clr_mask[i])
        st_nxt.flag[i] = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign flags = st_r.flag;

  // Per-bit checks
  for (genvar g = 0; g < W; g++) begin : g_chk
    a_clear_wins_not: assert property (
      @(posedge clk) disable iff (!nrst) set_evt[g] |=> flags[g])
      else $error("flag not set after event");
    a_w1c_clears: assert property (
      @(posedge clk) disable iff (!nrst)
      clr_mask[g] && !set_evt[g] |=> !flags[g])
      else $error("write one did not clear flag");
    a_flag_holds: assert property (
      @(posedge clk) disable iff (!nrst)
      !clr_mask[g] && !set_evt[g] |=> $stable(flags[g]))
      else $error("flag changed without cause");
  end
endmodule : siu_flag_bank

// ---- siu_status_irq.sv ----
// Status and interrupt unit: event status, enables, chip condition,
// power signs, checksum, frequency ratio and host write lock.
// Assumes the serial engine gives one-cycle read and write strobes with
// page, address and data, and that all event inputs are clk-synchronous.
`timescale 1ns/100ps
module siu_status_irq #(
  parameter int unsigned DW = siu_pkg::DW
) (
  input  wire logic          clk,
  input  wire logic          nrst,
  // Register access from the serial engine
  input  wire logic          reg_wr_en,
  input  wire logic          reg_rd_en,
  input  wire logic [7:0]    reg_page,
  input  wire logic [5:0]    reg_addr,
  input  wire logic [DW-1:0] reg_wdata,
  output logic      [DW-1:0] reg_rdata,
  output logic               reg_rvalid,
  // Event pulses
  input  wire logic          low_rate_update,
  input  wire logic          instr_done,
  input  wire logic          sample_update,
  input  wire logic          watchdog_ovf,
  input  wire logic          compute_overrun,
  input  wire logic          swell_det,
  input  wire logic          sag_det,
  input  wire logic          power_ovf,
  input  wire logic          current_ovf,
  input  wire logic          voltage_ovf,
  input  wire logic          overcurrent_det,
  input  wire logic          temp_update,
  input  wire logic          cmd_invalid,
  input  wire logic          rx_checksum_error,
  input  wire logic          rx_timeout_evt,
  // Command, oscillation and sign levels
  input  wire logic          cmd_exec,
  input  wire logic [7:0]    cmd_code,
  input  wire logic          temp_mod_osc,
  input  wire logic          volt_mod_osc,
  input  wire logic          curr_mod_osc,
  input  wire logic          reactive_total_sign,
  input  wire logic          reactive_avg_sign,
  input  wire logic          active_total_sign,
  input  wire logic          active_avg_sign,
  // Checksum and frequency ratio engines
  input  wire logic          checksum_valid,
  input  wire logic [DW-1:0] checksum_value,
  input  wire logic          auto_freq_calc,
  input  wire logic          ratio_valid,
  input  wire logic [DW-1:0] ratio_value,
  // Outputs
  output logic               event_irq,
  output logic               host_locked
);
  typedef struct packed {
    logic [DW-1:0]              enable;
    logic [siu_pkg::LOCK_W-1:0] lock;
    logic [DW-1:0]              cond;
    logic [DW-1:0]              sign;
    logic [DW-1:0]              chk;
    logic [DW-1:0]              ratio;
    logic [DW-1:0]              rdata;
    logic                       rvalid;
    logic                       irq;
    logic                       locked;
  } siu_main_s;

  siu_main_s      st_r;
  siu_main_s      st_nxt;
  logic [DW-1:0]  flag_q;
  logic [DW-1:0]  set_vec;
  logic [DW-1:0]  clr_vec;
  logic           pg_ctrl;
  logic           pg_cal;
  logic           sel_enable;
  logic           sel_status;
  logic           sel_lock;
  logic           sel_ratio;
  logic           ratio_host;
  logic           ratio_upd;

  initial begin
    if (DW != siu_pkg::DW) $error("siu_status_irq: DW must be 24");
  end

  // Address decode
  assign pg_ctrl    = (reg_page == siu_pkg::PAGE_CTRL);
  assign pg_cal     = (reg_page == siu_pkg::PAGE_CAL);
  assign sel_enable = pg_ctrl && (reg_addr == siu_pkg::ADDR_ENABLE);
  assign sel_status = pg_ctrl && (reg_addr == siu_pkg::ADDR_STATUS);
  assign sel_lock   = pg_ctrl && (reg_addr == siu_pkg::ADDR_LOCK);
  assign sel_ratio  = pg_cal  && (reg_addr == siu_pkg::ADDR_RATIO);

  // Host ratio writes are refused while locked; auto values win a tie
  assign ratio_host = reg_wr_en && sel_ratio && !st_r.locked;
  assign ratio_upd  = ratio_host || (auto_freq_calc && ratio_valid);

  // Event set vector, one source per implemented bit except B_LOW_RATE (low_rate_update or instr_done) and B_FREQ_UPD (host or auto ratio update)
  always_comb begin
    set_vec = '0;
    set_vec[siu_pkg::B_LOW_RATE]   = low_rate_update | instr_done;
    set_vec[siu_pkg::B_SAMPLE]     = sample_update;
    set_vec[siu_pkg::B_WATCHDOG]   = watchdog_ovf;
    set_vec[siu_pkg::B_OVERRUN]    = compute_overrun;
    set_vec[siu_pkg::B_SWELL]      = swell_det;
    set_vec[siu_pkg::B_SAG]        = sag_det;
    set_vec[siu_pkg::B_POWER_RNG]  = power_ovf;
    set_vec[siu_pkg::B_CURR_RNG]   = current_ovf;
    set_vec[siu_pkg::B_VOLT_RNG]   = voltage_ovf;
    set_vec[siu_pkg::B_OVERCURR]   = overcurrent_det;
    set_vec[siu_pkg::B_TEMP_UPD]   = temp_update;
    set_vec[siu_pkg::B_FREQ_UPD]   = ratio_upd;
    set_vec[siu_pkg::B_BAD_CMD]    = cmd_invalid;
    set_vec[siu_pkg::B_RX_CSUM]    = rx_checksum_error;
    set_vec[siu_pkg::B_RX_TIMEOUT] = rx_timeout_evt;
  end

  // Status clears are never locked out
  assign clr_vec = (reg_wr_en && sel_status) ?
                   (reg_wdata & siu_pkg::STATUS_IMPL) : '0;

  siu_flag_bank #(
    .W (DW)
  ) u_flags (
    .clk      (clk),
    .nrst     (nrst),
    .set_evt  (set_vec),
    .clr_mask (clr_vec),
    .flags    (flag_q)
  );

  // Next-state logic for registers, read data and interrupt
  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = reg_rd_en;
    // Lock register only reacts to the two codes
    if (reg_wr_en && sel_lock) begin
      if (reg_wdata[siu_pkg::LOCK_W-1:0] == siu_pkg::LOCK_CODE) begin
        st_nxt.lock   = siu_pkg::LOCK_CODE;
        st_nxt.locked = 1'b1;
      end else if (reg_wdata[siu_pkg::LOCK_W-1:0] ==
                   siu_pkg::UNLOCK_CODE) begin
        st_nxt.lock   = siu_pkg::UNLOCK_CODE;
        st_nxt.locked = 1'b0;
      end
    end
    if (reg_wr_en && sel_enable && !st_r.locked)
      st_nxt.enable = reg_wdata & siu_pkg::STATUS_IMPL;
    // Host write first, auto result overrides it in the same cycle
    if (ratio_host)
      st_nxt.ratio = reg_wdata;
    if (auto_freq_calc && ratio_valid)
      st_nxt.ratio = ratio_value;
    if (cmd_exec)
      st_nxt.cond[siu_pkg::C_CMD_LO +: 8] = cmd_code;
    st_nxt.cond[siu_pkg::C_TEMP_OSC] = temp_mod_osc;
    st_nxt.cond[siu_pkg::C_VOLT_OSC] = volt_mod_osc;
    st_nxt.cond[siu_pkg::C_CURR_OSC] = curr_mod_osc;
    st_nxt.sign[siu_pkg::S_REACT_TOT] = reactive_total_sign;
    st_nxt.sign[siu_pkg::S_REACT_AVG] = reactive_avg_sign;
    st_nxt.sign[siu_pkg::S_ACT_TOT]   = active_total_sign;
    st_nxt.sign[siu_pkg::S_ACT_AVG]   = active_avg_sign;
    if (checksum_valid)
      st_nxt.chk = checksum_value;
    // Interrupt follows flags one cycle later so the pin is a flop
    st_nxt.irq = |(flag_q & st_r.enable);
    // Read mux, unmapped reads answer zero
    st_nxt.rdata = siu_pkg::RST_ZERO;
    if (reg_rd_en) begin
      if (sel_enable)
        st_nxt.rdata = st_r.enable;
      else if (sel_status)
        st_nxt.rdata = flag_q;
      else if (pg_ctrl && reg_addr == siu_pkg::ADDR_COND)
        st_nxt.rdata = st_r.cond;
      else if (pg_ctrl && reg_addr == siu_pkg::ADDR_SIGN)
        st_nxt.rdata = st_r.sign;
      else if (sel_lock)
        st_nxt.rdata = {{(DW - siu_pkg::LOCK_W){1'b0}}, st_r.lock};
      else if (pg_cal && reg_addr == siu_pkg::ADDR_CHECKSUM)
        st_nxt.rdata = st_r.chk;
      else if (sel_ratio)
        st_nxt.rdata = st_r.ratio;
    end
  end

  // State register; ratio resets to its nominal 50 Hz value
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r        <= '0;
      st_r.ratio  <= siu_pkg::RST_RATIO;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state flops
  assign reg_rdata   = st_r.rdata;
  assign reg_rvalid  = st_r.rvalid;
  assign event_irq   = st_r.irq;
  assign host_locked = st_r.locked;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_irq_asserts: assert property (
    |(flag_q & st_r.enable) |=> event_irq)
    else $error("interrupt missing for enabled flag");
  a_irq_releases: assert property (
    (flag_q & st_r.enable) == '0 |=> !event_irq)
    else $error("interrupt active with no enabled flag");
  a_lock_blocks: assert property (
    host_locked && reg_wr_en && sel_enable |=> $stable(st_r.enable))
    else $error("enable written while locked");
  a_lock_ratio: assert property (
    host_locked && reg_wr_en && sel_ratio && !auto_freq_calc
    |=> $stable(st_r.ratio))
    else $error("ratio written while locked");
  a_ratio_flag: assert property (
    $changed(st_r.ratio) |-> flag_q[siu_pkg::B_FREQ_UPD])
    else $error("ratio changed without update flag");
  a_last_cmd: assert property (
    cmd_exec |=> st_r.cond[siu_pkg::C_CMD_LO +: 8] == $past(cmd_code))
    else $error("last command code not captured");
  a_low_rate: assert property (
    instr_done |=> flag_q[siu_pkg::B_LOW_RATE])
    else $error("low rate flag not set on instruction done");
  a_sign_track: assert property (
    ##1 st_r.sign[siu_pkg::S_REACT_TOT] == $past(reactive_total_sign, 1)
    && st_r.sign[siu_pkg::S_ACT_AVG] == $past(active_avg_sign, 1))
    else $error("power sign not tracked");
  a_rd_unmapped: assert property (
    reg_rd_en && !pg_ctrl && !pg_cal |=> reg_rvalid && reg_rdata == '0)
    else $error("unmapped read not zero");
  a_checksum_ld: assert property (
    checksum_valid |=> st_r.chk == $past(checksum_value))
    else $error("checksum not loaded");

  // Read port: exactly one answer per read, quiet zeros otherwise, so
  // the serial engine can OR the answer into its shift path safely
  a_rvalid_once: assert property (
    reg_rd_en |=> reg_rvalid)
    else $error("read strobe without answer");
  a_rdata_idle: assert property (
    !reg_rd_en |=> !reg_rvalid && reg_rdata == '0)
    else $error("read port not idle");
  a_rd_status: assert property (
    reg_rd_en && sel_status |=> reg_rdata == $past(flag_q))
    else $error("status read differs from flags");
  a_enable_wr: assert property (
    reg_wr_en && sel_enable && !host_locked
    |=> st_r.enable == ($past(reg_wdata) & siu_pkg::STATUS_IMPL))
    else $error("enable write not applied");

  // Lock and unlock codes take effect on the next edge
  a_lock_set: assert property (
    reg_wr_en && sel_lock
    && reg_wdata[siu_pkg::LOCK_W-1:0] == siu_pkg::LOCK_CODE
    |=> host_locked)
    else $error("lock code did not lock");
  a_unlock_clr: assert property (
    reg_wr_en && sel_lock
    && reg_wdata[siu_pkg::LOCK_W-1:0] == siu_pkg::UNLOCK_CODE
    |=> !host_locked)
    else $error("unlock code did not unlock");

  // Ratio and oscillation values follow their engines
  a_auto_ratio: assert property (
    auto_freq_calc && ratio_valid |=> st_r.ratio == $past(ratio_value))
    else $error("auto ratio not loaded");
  a_osc_track: assert property (
    ##1 st_r.cond[siu_pkg::C_TEMP_OSC] == $past(temp_mod_osc, 1)
    && st_r.cond[siu_pkg::C_VOLT_OSC] == $past(volt_mod_osc, 1)
    && st_r.cond[siu_pkg::C_CURR_OSC] == $past(curr_mod_osc, 1))
    else $error("oscillation flag not tracked");

  // Each event source below lands in its status bit one edge later; overcurrent_det and low_rate_update have no such check
  a_sample_flag: assert property (
    sample_update |=> flag_q[siu_pkg::B_SAMPLE])
    else $error("sample done flag not set");
  a_watchdog_flag: assert property (
    watchdog_ovf |=> flag_q[siu_pkg::B_WATCHDOG])
    else $error("watchdog flag not set");
  a_overrun_flag: assert property (
    compute_overrun |=> flag_q[siu_pkg::B_OVERRUN])
    else $error("compute overrun flag not set");
  a_swell_flag: assert property (
    swell_det |=> flag_q[siu_pkg::B_SWELL])
    else $error("swell flag not set");
  a_sag_flag: assert property (
    sag_det |=> flag_q[siu_pkg::B_SAG])
    else $error("sag flag not set");
  a_power_flag: assert property (
    power_ovf |=> flag_q[siu_pkg::B_POWER_RNG])
    else $error("power range flag not set");
  a_curr_flag: assert property (
    current_ovf |=> flag_q[siu_pkg::B_CURR_RNG])
    else $error("current range flag not set");
  a_volt_flag: assert property (
    voltage_ovf |=> flag_q[siu_pkg::B_VOLT_RNG])
    else $error("voltage range flag not set");
  a_temp_flag: assert property (
    temp_update |=> flag_q[siu_pkg::B_TEMP_UPD])
    else $error("temperature flag not set");
  a_badcmd_flag: assert property (
    cmd_invalid |=> flag_q[siu_pkg::B_BAD_CMD])
    else $error("bad command flag not set");
  a_csum_flag: assert property (
    rx_checksum_error |=> flag_q[siu_pkg::B_RX_CSUM])
    else $error("receive checksum flag not set");
  a_rxto_flag: assert property (
    rx_timeout_evt |=> flag_q[siu_pkg::B_RX_TIMEOUT])
    else $error("receive timeout flag not set");

  c_irq_rise:   cover property (!event_irq ##1 event_irq);
  c_lock_write: cover property (host_locked && reg_wr_en && sel_enable);
  c_auto_ratio: cover property (auto_freq_calc && ratio_valid);
  c_set_clear:  cover property (reg_wr_en && sel_status && |set_vec);
endmodule : siu_status_irq

// ---- siu_host_model.sv ----
// Host side of the register port: write and read access tasks.
// Assumes one bench process calls the tasks, never two at once.
`timescale 1ns/100ps
module siu_host_model (
  input  wire logic        clk,
  output logic             reg_wr_en,
  output logic             reg_rd_en,
  output logic [7:0]       reg_page,
  output logic [5:0]       reg_addr,
  output logic [23:0]      reg_wdata,
  input  wire logic [23:0] reg_rdata,
  input  wire logic        reg_rvalid
);
  // Port idles with both strobes low
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_page  = 8'h00;
    reg_addr  = 6'h00;
    reg_wdata = 24'h00_0000;
  end

  // One-cycle write strobe; stale data is scrambled once released
  task automatic wr(input logic [7:0] p, input logic [5:0] a,
                    input logic [23:0] d);
    @(negedge clk);
    reg_page  = p;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge clk);
    reg_wr_en = 1'b0;
    reg_wdata = ~d;
  endtask : wr

  // Read; the answer stands for the one cycle after the taking edge
  task automatic rd(input logic [7:0] p, input logic [5:0] a,
                    output logic [23:0] d, output logic v);
    @(negedge clk);
    reg_page  = p;
    reg_addr  = a;
    reg_rd_en = 1'b1;
    @(negedge clk);
    d         = reg_rdata;
    v         = reg_rvalid;
    reg_rd_en = 1'b0;
    reg_addr  = ~a;
  endtask : rd
endmodule : siu_host_model

// ---- testbench.sv ----
// Self-checking bench of the status and interrupt unit.
// Assumes the host model owns the register port; the bench owns events.
`timescale 1ns/100ps
module testbench;
  logic        clk;
  logic        nrst;
  logic [17:0] ev;
  logic [6:0]  lv;
  logic [7:0]  cmd_code;
  logic [23:0] chk_val;
  logic [23:0] rat_val;
  logic        afc;
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  page;
  logic [5:0]  addr;
  logic [23:0] wdata;
  logic [23:0] rdata;
  logic        rvalid;
  logic        irq;
  logic        locked;
  int          miscompares = 0;
  int          tests_run   = 0;
  int          cycles      = 0;
  localparam int EVB [15] = '{23, 23, 22, 21, 18, 16, 6, 14, 12, 10,
                              8, 5, 3, 2, 0};
  localparam logic [5:0] RA [8] = '{6'h03, 6'h17, 6'h18, 6'h19,
                                    6'h22, 6'h01, 6'h31, 6'h3f};

  siu_host_model host (.clk(clk), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
    .reg_page(page), .reg_addr(addr), .reg_wdata(wdata),
    .reg_rdata(rdata), .reg_rvalid(rvalid));

  siu_status_irq dut (.clk(clk), .nrst(nrst), .reg_wr_en(wr_en),
    .reg_rd_en(rd_en), .reg_page(page), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid),
    .low_rate_update(ev[0]), .instr_done(ev[1]), .sample_update(ev[2]),
    .watchdog_ovf(ev[3]), .compute_overrun(ev[4]), .swell_det(ev[5]),
    .sag_det(ev[6]), .power_ovf(ev[7]), .current_ovf(ev[8]),
    .voltage_ovf(ev[9]), .overcurrent_det(ev[10]), .temp_update(ev[11]),
    .cmd_invalid(ev[12]), .rx_checksum_error(ev[13]), .rx_timeout_evt(ev[14]),
    .cmd_exec(ev[15]), .cmd_code(cmd_code), .temp_mod_osc(lv[0]),
    .volt_mod_osc(lv[1]), .curr_mod_osc(lv[2]),
    .reactive_total_sign(lv[3]), .reactive_avg_sign(lv[4]),
    .active_total_sign(lv[5]), .active_avg_sign(lv[6]),
    .checksum_valid(ev[16]), .checksum_value(chk_val),
    .auto_freq_calc(afc), .ratio_valid(ev[17]), .ratio_value(rat_val),
    .event_irq(irq), .host_locked(locked));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Read and compare, also that the answer came on time
  task automatic rchk(input logic [7:0] p, input logic [5:0] a,
                      input logic [23:0] exp);
    logic [23:0] d;
    logic        v;
    host.rd(p, a, d, v);
    check({23'h00_0000, v}, 24'h00_0001);
    check(d, exp);
  endtask : rchk

  // One-cycle pulse on an event or load strobe
  task automatic pulse(input int i);
    @(negedge clk);
    ev[i] = 1'b1;
    @(negedge clk);
    ev[i] = 1'b0;
  endtask : pulse

  task automatic stop_test();
    $display("Counts: %0d compares, %0d mismatches", tests_run,
             miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    nrst     = 1'b0;
    ev       = '0;
    lv       = '0;
    cmd_code = 8'h00;
    chk_val  = 24'h00_0000;
    rat_val  = 24'h00_0000;
    afc      = 1'b0;
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    // Reset values, with an unmapped page and address last
    for (int i = 0; i < 8; i++) begin
      rchk((i == 5 || i == 6) ? 8'h10 : (i == 7) ? 8'h20 : 8'h00, RA[i],
           (i == 6) ? 24'h01_999a : 24'h00_0000);
    end
    $display("test reset_values done");
    // Each source sets its bit; zeros leave it, a one clears it
    for (int i = 0; i < 15; i++) begin
      pulse(i);
      rchk(8'h00, 6'h17, 24'h1 << EVB[i]);
      host.wr(8'h00, 6'h17, ~(24'h1 << EVB[i]));
      rchk(8'h00, 6'h17, 24'h1 << EVB[i]);
      host.wr(8'h00, 6'h17, 24'h1 << EVB[i]);
      rchk(8'h00, 6'h17, 24'h00_0000);
    end
    afc     = 1'b1;
    rat_val = 24'h02_3456;
    pulse(17);
    rchk(8'h10, 6'h31, 24'h02_3456);
    rchk(8'h00, 6'h17, 24'h00_0010);
    host.wr(8'h00, 6'h17, 24'h00_0010);
    // With auto calculation off a ratio result must be ignored
    afc     = 1'b0;
    rat_val = 24'h07_7777;
    pulse(17);
    rchk(8'h10, 6'h31, 24'h02_3456);
    rchk(8'h00, 6'h17, 24'h00_0000);
    $display("test event_flags done");
    // Interrupt follows flag and enable
    host.wr(8'h00, 6'h03, 24'hff_ffff);
    rchk(8'h00, 6'h03, 24'he5_557d);
    host.wr(8'h00, 6'h03, 24'h00_0040);
    pulse(6);
    repeat (2) @(negedge clk);
    check({23'h00_0000, irq}, 24'h00_0001);
    host.wr(8'h00, 6'h03, 24'h00_0000);
    @(negedge clk);
    check({23'h00_0000, irq}, 24'h00_0000);
    host.wr(8'h00, 6'h03, 24'h00_0040);
    @(negedge clk);
    check({23'h00_0000, irq}, 24'h00_0001);
    host.wr(8'h00, 6'h17, 24'h00_0040);
    @(negedge clk);
    check({23'h00_0000, irq}, 24'h00_0000);
    $display("test interrupt done");
    // Command code, oscillation and sign fields
    cmd_code = 8'ha5;
    lv       = 7'h7f;
    pulse(15);
    rchk(8'h00, 6'h18, 24'h00_a50d);
    rchk(8'h00, 6'h19, 24'h00_002d);
    lv = 7'h2a;
    host.wr(8'h00, 6'h18, 24'hff_ffff);
    rchk(8'h00, 6'h18, 24'h00_a504);
    rchk(8'h00, 6'h19, 24'h00_0024);
    chk_val = 24'h5a_c3e1;
    pulse(16);
    host.wr(8'h10, 6'h01, 24'h00_0000);
    rchk(8'h10, 6'h01, 24'h5a_c3e1);
    $display("test read_only done");
    // Host write lock
    host.wr(8'h00, 6'h22, 24'h00_0016);
    check({23'h00_0000, locked}, 24'h00_0001);
    host.wr(8'h00, 6'h03, 24'h00_0000);
    rchk(8'h00, 6'h03, 24'h00_0040);
    host.wr(8'h10, 6'h31, 24'h00_1234);
    rchk(8'h10, 6'h31, 24'h02_3456);
    pulse(6);
    host.wr(8'h00, 6'h17, 24'h00_0040);
    rchk(8'h00, 6'h17, 24'h00_0000);
    rchk(8'h00, 6'h22, 24'h00_0016);
    host.wr(8'h00, 6'h22, 24'h00_0009);
    check({23'h00_0000, locked}, 24'h00_0000);
    host.wr(8'h10, 6'h31, 24'h00_1234);
    rchk(8'h10, 6'h31, 24'h00_1234);
    rchk(8'h00, 6'h17, 24'h00_0010);
    $display("test host_lock done");
    stop_test();
  end
endmodule : testbench
